// ### core/sfr_pkg.sv
// Constants, register layout and bus carriers for the core register bank
// Functional notes
// - Decode the bottom 2 Kbytes, 0000h to 07FFh, as the register region.
// - Reads of unimplemented addresses inside the region return zero.
// - Region is split in 32-byte blocks; only blocks holding registers decode.
// - Reset loads zero, working reg 15 gets 0800; three counters stay undefined.
// - Unimplemented bits of a register read zero and ignore writes.
// - Accesses beyond the 8-Kbyte data area return an all-zero word or byte.
// - Byte writes change only the lane chosen by address bit 0.
// - Word access to an odd address flags an address error and writes nothing.
package sfr_pkg;

   localparam int          NREG          = 25;
   localparam int          REGION_BITS   = 6;
   localparam int          REGION_SHIFT  = 5;
   localparam logic [15:0] SFR_LAST_ADDR = 16'h07FF;
   localparam logic [15:0] DATA_LIMIT    = 16'h2000;

   // Register indices into the bank
   localparam int IDX_WORKING_REG_15  = 15;
   localparam int IDX_STACK_LIMIT   = 16;
   localparam int IDX_STATUS  = 22;
   localparam int IDX_CORECTL = 23;

   // Byte offsets of the registers, index order
   localparam logic [15:0] REG_OFFSET [NREG] = '{
      16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E,
      16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001A, 16'h001C, 16'h001E,
      16'h0020, 16'h002E, 16'h0030, 16'h0032, 16'h0034, 16'h0036, 16'h0042, 16'h0044,
      16'h0052};

   // Implemented bit masks
   localparam logic [15:0] REG_MASK [NREG] = '{
      16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'hFFFF, 16'hFFFF, 16'h00FF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h01FF, 16'h000C,
      16'h3FFF};

   // Values after reset
   localparam logic [15:0] REG_RESET [NREG] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0800,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000};

   // Bit set where the register is loaded by reset
   // Stack limit (16), repeat count (21) and interrupt-disable count (24) hold across reset
   localparam logic [NREG-1:0] REG_HAS_RESET = 25'h0DE_FFFF;

   // One bit per 32-byte block of the region; only the core blocks hold registers here
   localparam logic [63:0] REGION_IMPL = 64'h0000_0000_0000_0007;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        rd;
      logic        wr;
      logic        byte_op;
   } bus_req_t;

   typedef struct packed {
      logic [15:0] rdata;
      logic        valid;
      logic        hit;
      logic        addr_err;
   } bus_rsp_t;

   typedef logic [NREG-1:0][15:0] reg_bank_t;

endpackage

// ### core/sfr_word_reg.sv
// One 16-bit register with byte-lane writes and an implemented-bit mask
module sfr_word_reg #(
   parameter logic [15:0] RESET_VAL = 16'h0000,
   parameter logic [15:0] MASK      = 16'hFFFF,
   parameter bit          HAS_RESET = 1'b1
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Lane strobes and data
   input  wire logic        wr_lo,
   input  wire logic        wr_hi,
   input  wire logic [15:0] wdata,
   output logic      [15:0] value
);

   logic [15:0] val_q;
   logic [15:0] val_d;

   // Lanes not strobed keep their byte; masked bits never hold a one
   assign val_d = {wr_hi ? wdata[15:8] : val_q[15:8],
                   wr_lo ? wdata[7:0]  : val_q[7:0]} & MASK;
   assign value = val_q & MASK;

   // Counters with no reset value simply hold across reset
   always_ff @(posedge core_clk)
   begin
      if (rst && HAS_RESET)
         val_q <= RESET_VAL;
      else
         val_q <= val_d;
   end

endmodule // sfr_word_reg

// ### core/sfr_region_map.sv
// Classifies a data address: register region, implemented block, data area
module sfr_region_map (
   // Address in
   input  wire logic [15:0] addr,
   // Classification
   output logic             in_region,
   output logic             block_impl,
   output logic             in_data_area
);
   import sfr_pkg::*;

   logic [REGION_BITS-1:0] block_idx;

   assign in_region    = (addr <= SFR_LAST_ADDR);
   assign block_idx    = addr[REGION_SHIFT +: REGION_BITS];
   assign block_impl   = in_region && REGION_IMPL[block_idx];
   assign in_data_area = (addr < DATA_LIMIT);

endmodule // sfr_region_map

// ### core/core_sfr_register_map.sv
// Core register bank: decode, byte-lane writes and read-back for the register region
module core_sfr_register_map (
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst,
   // Data bus from the core
   input  wire sfr_pkg::bus_req_t   req,
   output sfr_pkg::bus_rsp_t        rsp,
   // Register contents for the core datapath
   output sfr_pkg::reg_bank_t       regs,
   output logic               [15:0] stack_ptr,
   output logic               [15:0] cpu_status,
   output logic               [15:0] core_control
);
   import sfr_pkg::*;

   // Address classification
   logic        in_region;
   logic        block_impl;
   logic        in_data_area;

   // Access qualification
   logic        access;
   logic        misaligned;
   logic        wr_ok;
   logic        lane_lo;
   logic        lane_hi;
   logic [15:0] lane_wdata;

   // Per-register decode
   logic [NREG-1:0]  reg_hit;
   logic [NREG-1:0]  wr_lo;
   logic [NREG-1:0]  wr_hi;
   reg_bank_t        bank;

   // Read path
   logic [15:0] word_rd;
   logic [15:0] rd_lane;
   logic        any_hit;

   // Registered answer
   bus_rsp_t    rsp_q;
   bus_rsp_t    rsp_d;
   reg_bank_t   regs_q;

   sfr_region_map u_region (
      .addr         (req.addr),
      .in_region    (in_region),
      .block_impl   (block_impl),
      .in_data_area (in_data_area)
   );

   assign access     = req.rd || req.wr;

   // A word access must sit on an even address
   assign misaligned = access && !req.byte_op && req.addr[0];

   // Misaligned writes are dropped whole, not half done
   assign wr_ok      = req.wr && !misaligned && block_impl;

   // Byte writes go only to the lane that the address bit picks
   assign lane_lo    = !req.byte_op || !req.addr[0];
   assign lane_hi    = !req.byte_op ||  req.addr[0];

   // A byte sits in the low lane of the bus; mirror it so either lane can take it
   assign lane_wdata = req.byte_op ? {req.wdata[7:0], req.wdata[7:0]} : req.wdata;

   generate
      for (genvar i = 0; i < NREG; i++)
      begin : g_reg
         // Word decode ignores bit 0 so both bytes of a register match
         assign reg_hit[i] = block_impl &&
                             (req.addr[15:1] == REG_OFFSET[i][15:1]);
         assign wr_lo[i]   = wr_ok && reg_hit[i] && lane_lo;
         assign wr_hi[i]   = wr_ok && reg_hit[i] && lane_hi;

         sfr_word_reg #(
            .RESET_VAL (REG_RESET[i]),
            .MASK      (REG_MASK[i]),
            .HAS_RESET (REG_HAS_RESET[i])
         ) u_reg (
            .core_clk (core_clk),
            .rst      (rst),
            .wr_lo    (wr_lo[i]),
            .wr_hi    (wr_hi[i]),
            .wdata    (lane_wdata),
            .value    (bank[i])
         );
      end
   endgenerate

   // Offsets are unique, so an OR of the selected words is the read mux
   always_comb
   begin
      word_rd = 16'h0000;
      for (int i = 0; i < NREG; i++)
      begin
         if (reg_hit[i])
            word_rd = word_rd | bank[i];
      end
   end

   assign any_hit = |reg_hit;

   // A byte read returns the chosen byte in the low lane, upper lane zero
   assign rd_lane = !req.byte_op ? word_rd :
                    req.addr[0]  ? {8'h00, word_rd[15:8]} :
                                   {8'h00, word_rd[7:0]};

   // Empty addresses, empty blocks and addresses past the data area read zero
   always_comb
   begin
      rsp_d          = '0;
      rsp_d.valid    = access;
      rsp_d.addr_err = misaligned;
      rsp_d.hit      = access && any_hit && in_data_area;
      // A misaligned word read still flags, but its data is forced to zero
      if (req.rd && !req.wr && !misaligned && in_data_area && block_impl)
         rsp_d.rdata = rd_lane;
      else
         rsp_d.rdata = 16'h0000;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         rsp_q <= '0;
      else
         rsp_q <= rsp_d;
   end

   // Bank view is registered so the datapath sees values one edge after a write
   always_ff @(posedge core_clk)
   begin
      regs_q <= bank;
   end

   assign rsp          = rsp_q;
   assign regs         = regs_q;
   assign stack_ptr    = regs_q[IDX_WORKING_REG_15];
   assign cpu_status   = regs_q[IDX_STATUS];
   assign core_control = regs_q[IDX_CORECTL];

endmodule // core_sfr_register_map

// ### sim/core_sfr_register_map_properties.sv
// Port-level assertions for the core register bank
module core_sfr_register_map_properties
   import sfr_pkg::*;
(
   // Clock and reset
   input wire logic              core_clk,
   input wire logic              rst,
   // Bus and contents
   input wire sfr_pkg::bus_req_t  req,
   input wire sfr_pkg::bus_rsp_t  rsp,
   input wire sfr_pkg::reg_bank_t regs,
   input wire logic [15:0]        stack_ptr,
   input wire logic [15:0]        cpu_status,
   input wire logic [15:0]        core_control
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_valid; (req.rd || req.wr) |=> rsp.valid; endproperty
   a_valid: assert property (p_valid) else $error("no answer pulse");
   property p_hit; (req.rd || req.wr) && !req.byte_op && req.addr == 16'h0002 |=> rsp.hit; endproperty
   a_hit: assert property (p_hit) else $error("core register missed");
   property p_odd; (req.rd || req.wr) && !req.byte_op && req.addr[0] |=> rsp.addr_err && rsp.rdata == 16'h0000; endproperty
   a_odd: assert property (p_odd) else $error("odd word access not flagged");
   property p_empty; req.rd && req.addr inside {[16'h0038:16'h003F], [16'h0060:16'h07FF]} |=> !rsp.hit && rsp.rdata == 16'h0000; endproperty
   a_empty: assert property (p_empty) else $error("empty place read nonzero");
   property p_far; req.rd && req.addr >= 16'h0800 |=> rsp.rdata == 16'h0000; endproperty
   a_far: assert property (p_far) else $error("outside read nonzero");
   property p_reset; $fell(rst) |-> rsp == '0 ##1 (stack_ptr == 16'h0800 && cpu_status == 16'h0000 && core_control == 16'h0000); endproperty
   a_reset: assert property (p_reset) else $error("reset values wrong");
   property p_lane; req.wr && !req.rd && req.byte_op && req.addr == 16'h0002 |-> ##2 regs[1][7:0] == $past(req.wdata[7:0], 2) && regs[1][15:8] == $past(regs[1][15:8]); endproperty
   a_lane: assert property (p_lane) else $error("byte lane write wrong");
   property p_mask; req.wr && !req.rd && !req.byte_op && req.addr == 16'h0044 |-> ##2 regs[23] == ($past(req.wdata, 2) & 16'h000C); endproperty
   a_mask: assert property (p_mask) else $error("unimplemented bits kept");
endmodule // core_sfr_register_map_properties

bind core_sfr_register_map core_sfr_register_map_properties i_core_sfr_register_map_properties (
   .core_clk(core_clk), .rst(rst), .req(req), .rsp(rsp), .regs(regs),
   .stack_ptr(stack_ptr), .cpu_status(cpu_status), .core_control(core_control));

// ### sim/core_sfr_register_map_bench.sv
// Self-checking bench for the core register bank
module core_sfr_register_map_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import sfr_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   bus_req_t    req = '0;
   bus_rsp_t    rsp;
   reg_bank_t   regs;
   logic [15:0] stack_ptr;
   logic [15:0] cpu_status;
   logic [15:0] core_control;
   logic [15:0] rd_q;
   logic [15:0] shadow [NREG];
   logic [15:0] corner [7] = '{16'h0038, 16'h0046, 16'h0060, 16'h07FE, 16'h0800, 16'h1FFE, 16'hFFFE};
   logic        err_q;
   logic        hit_q;
   int          num_errors = 0;
   int          compares = 0;
   int          seed = 65;

   core_sfr_register_map i_core_sfr_register_map (.core_clk(core_clk), .rst(rst), .req(req),
      .rsp(rsp), .regs(regs), .stack_ptr(stack_ptr), .cpu_status(cpu_status),
      .core_control(core_control));

   initial
   begin
      forever #50 core_clk = ~core_clk;
   end

   function automatic logic [15:0] expw(int i, logic [15:0] v);
      return v & REG_MASK[i];
   endfunction

   task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Request stays up until the next call changes it; each call returns at the next falling edge, so calls may run back to back
   task automatic acc(logic rd, logic wr, logic bo, logic [15:0] a, logic [15:0] d);
      req = '{addr: a, wdata: d, rd: rd, wr: wr, byte_op: bo};
      @(negedge core_clk);
      rd_q = rsp.rdata;
      err_q = rsp.addr_err;
      hit_q = rsp.hit;
      chk("valid", {15'h0000, rsp.valid}, 16'h0001);
   endtask

   task automatic check_reset();
      for (int i = 0; i < NREG; i++)
         if (REG_HAS_RESET[i])
         begin
            acc(1'b1, 1'b0, 1'b0, REG_OFFSET[i], 16'h0000);
            chk("reset", rd_q, REG_RESET[i]);
         end
      chk("stack_ptr", stack_ptr, 16'h0800);
      chk("cpu_status", cpu_status, 16'h0000);
      chk("core_control", core_control, 16'h0000);
   endtask

   task automatic final_report();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      logic [15:0] v;
      repeat (12) @(negedge core_clk);
      rst = 1'b0;
      check_reset();
      for (int i = 0; i < NREG; i++)
      begin
         shadow[i] = 16'($random(seed));
         acc(1'b0, 1'b1, 1'b0, REG_OFFSET[i], shadow[i]);
      end
      for (int i = 0; i < NREG; i++)
      begin
         acc(1'b1, 1'b0, 1'b0, REG_OFFSET[i], 16'h0000);
         chk("word", rd_q, expw(i, shadow[i]));
         chk("hit", {15'h0000, hit_q}, 16'h0001);
         chk("bank", regs[i], expw(i, shadow[i]));
      end
      chk("status_out", cpu_status, expw(IDX_STATUS, shadow[IDX_STATUS]));
      chk("control_out", core_control, expw(IDX_CORECTL, shadow[IDX_CORECTL]));
      // Upper byte of wdata carries junk that a byte write must drop
      v = 16'($random(seed));
      acc(1'b0, 1'b1, 1'b1, 16'h0002, v);
      acc(1'b0, 1'b1, 1'b1, 16'h0003, {v[7:0], v[15:8]});
      acc(1'b0, 1'b1, 1'b1, 16'h0004, v);
      acc(1'b1, 1'b0, 1'b1, 16'h0003, 16'h0000);
      chk("byte_hi", rd_q, {8'h00, v[15:8]});
      acc(1'b1, 1'b0, 1'b0, 16'h0004, 16'h0000);
      chk("lane", rd_q, {shadow[2][15:8], v[7:0]});
      acc(1'b0, 1'b1, 1'b0, 16'h0005, ~v);
      chk("odd_err", {15'h0000, err_q}, 16'h0001);
      acc(1'b1, 1'b0, 1'b0, 16'h0004, 16'h0000);
      chk("odd_keep", rd_q, {shadow[2][15:8], v[7:0]});
      acc(1'b1, 1'b0, 1'b0, 16'h0005, 16'h0000);
      chk("odd_rd_err", {15'h0000, err_q}, 16'h0001);
      chk("odd_rd_data", rd_q, 16'h0000);
      // Read and write together: the write lands, the read answers zero
      acc(1'b1, 1'b1, 1'b0, 16'h0006, v);
      chk("rdwr_data", rd_q, 16'h0000);
      acc(1'b1, 1'b0, 1'b0, 16'h0006, 16'h0000);
      chk("rdwr_write", rd_q, v);
      for (int k = 0; k < 47; k++)
      begin
         v = (k < 7) ? corner[k] : ((16'($random(seed)) | 16'h0060) & 16'hFFFE);
         acc(1'b0, 1'b1, 1'b0, v, 16'hFFFF);
         acc(1'b1, 1'b0, 1'b0, v, 16'h0000);
         chk("empty", rd_q, 16'h0000);
         chk("empty_hit", {15'h0000, hit_q}, 16'h0000);
      end
      acc(1'b1, 1'b0, 1'b0, 16'h0000, 16'h0000);
      chk("alias", rd_q, expw(0, shadow[0]));
      req.rd = 1'b0;
      rst = 1'b1;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      check_reset();
      req.rd = 1'b0;
      @(negedge core_clk);
      final_report();
   end
endmodule // core_sfr_register_map_bench
